// ### rtl/gpcb_pkg.sv
package gpcb_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int GPCB_PINS   = 16;     // pins in the bank
    localparam int GPCB_DATA_W = 32;     // bus data width
    localparam int GPCB_ADDR_W = 12;     // bus byte address width

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] GPCB_FUNC_OFS = 12'h418; // function select
    localparam logic [11:0] GPCB_DIR_OFS  = 12'h41C; // direction config
    localparam logic [11:0] GPCB_DATA_OFS = 12'h420; // data value

    // ------------------------------------------------------------
    // values after reset and fixed read values
    // ------------------------------------------------------------
    localparam logic [15:0] GPCB_FUNC_RST = 16'h0000; // all general use
    localparam logic [15:0] GPCB_DIR_RST  = 16'h0000; // all inputs
    localparam logic [15:0] GPCB_DOUT_RST = 16'h0000; // output latch
    localparam logic [15:0] GPCB_OEN_RST  = 16'hFFFF; // nothing driven
    localparam logic [15:0] GPCB_HI_ZERO  = 16'h0000; // reserved bits
    localparam logic [31:0] GPCB_RD_NONE  = 32'h0000_0000; // unmapped

    // ------------------------------------------------------------
    // pad drive: level and active-low output enable per pin
    // ------------------------------------------------------------
    typedef struct packed {
        logic [GPCB_PINS-1:0] out;      // level to drive
        logic [GPCB_PINS-1:0] oe_n;     // low while pin is driven
    } gpcb_pad_t;

endpackage : gpcb_pkg

// ### rtl/gpcb_pin_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser; a bit changes once stages two and three agree
module gpcb_pin_sync #(
    parameter int W = 16
) (
    input  wire logic         i_clk,
    input  wire logic         i_reset,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_level
);
    import gpcb_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] s1;               // metastable stage, read by s2 only
        logic [W-1:0] s2;               // second stage
        logic [W-1:0] s3;               // third stage
        logic [W-1:0] level;            // filtered level
    } gpcb_sync_state_t;

    gpcb_sync_state_t cur_reg;          // registered state
    gpcb_sync_state_t cur_next;         // next state

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // a lone one-cycle glitch in s2 never reaches level
    always_comb
    begin
        cur_next       = cur_reg;
        cur_next.s1    = i_async;
        cur_next.s2    = cur_reg.s1;
        cur_next.s3    = cur_reg.s2;
        cur_next.level = (~(cur_reg.s2 ^ cur_reg.s3) & cur_reg.s3)
                       | ((cur_reg.s2 ^ cur_reg.s3) & cur_reg.level);
        if (i_reset)
        begin
            cur_next = '0;
        end
    end

    // register the whole state
    always_ff @(posedge i_clk)
    begin
        cur_reg <= cur_next;
    end

    assign o_level = cur_reg.level;

endmodule : gpcb_pin_sync

// ### rtl/gpcb_top.sv
`timescale 1ns/1ps
// What this block does
// - function bit one hands pin to alternate
// - function bit zero makes pin general purpose
// - general pin with direction one drives
// - general pin with direction zero stays undriven
// - alternate pin ignores direction bit entirely
// - data read returns live level, all pins
// - data write drives only general output pins
module gpcb_top (
    input  wire logic                  i_clk,
    input  wire logic                  i_reset,       // fundamental
    input  wire logic                  i_soft_reset,  // lesser reset
    input  wire logic [11:0]           i_avs_address,
    input  wire logic                  i_avs_read,
    input  wire logic                  i_avs_write,
    input  wire logic [31:0]           i_avs_writedata,
    input  wire logic [3:0]            i_avs_byteenable,
    output logic      [31:0]           o_avs_readdata,
    output logic                       o_avs_waitrequest,
    input  wire logic [15:0]           i_pin_level,   // pad receivers
    input  wire gpcb_pkg::gpcb_pad_t   i_alt,         // alternate drive
    output gpcb_pkg::gpcb_pad_t        o_pad,         // pad drivers
    output logic      [15:0]           o_pin_level    // to alternate logic
);
    import gpcb_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [GPCB_PINS-1:0]   func;   // one = alternate function
        logic [GPCB_PINS-1:0]   dir;    // one = output when general
        logic [GPCB_PINS-1:0]   dout;   // output latch
        logic                   ack;    // bus answer cycle
        logic [GPCB_DATA_W-1:0] rdata;  // read data register
        gpcb_pad_t              pad;    // registered pad drive
    } gpcb_state_t;

    gpcb_state_t          cur_reg;      // registered state
    gpcb_state_t          cur_next;     // next state
    logic [GPCB_PINS-1:0] level;        // synchronised pin levels
    logic                 req;          // a bus request is present
    logic                 wr_acc;       // write takes effect this edge
    logic                 hit_func;     // address decodes
    logic                 hit_dir;
    logic                 hit_data;
    logic [31:0]          rd_val;       // read mux

    // ------------------------------------------------------------
    // pin input synchroniser
    // ------------------------------------------------------------
    gpcb_pin_sync #(
        .W       (GPCB_PINS)
    ) u_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_async (i_pin_level),
        .o_level (level)
    );

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // first request cycle always waits, so read data can come
    // from a flip-flop; the answer is one cycle later
    assign req      = i_avs_read | i_avs_write;
    assign wr_acc   = i_avs_write & cur_reg.ack;
    assign hit_func = (i_avs_address == GPCB_FUNC_OFS);
    assign hit_dir  = (i_avs_address == GPCB_DIR_OFS);
    assign hit_data = (i_avs_address == GPCB_DATA_OFS);

    // read mux; upper half reads zero, unmapped reads zero
    always_comb
    begin
        if (hit_func)
        begin
            rd_val = {GPCB_HI_ZERO, cur_reg.func};
        end
        else if (hit_dir)
        begin
            rd_val = {GPCB_HI_ZERO, cur_reg.dir};
        end
        else if (hit_data)
        begin
            rd_val = {GPCB_HI_ZERO, level};
        end
        else
        begin
            rd_val = GPCB_RD_NONE;
        end
    end

    // byte-lane merge of the low sixteen bits
    function automatic logic [15:0] gpcb_merge(
        input logic [15:0] old_val,
        input logic [31:0] wdata,
        input logic [3:0]  be
    );
        logic [15:0] res;
        res = old_val;
        if (be[0])
        begin
            res[7:0] = wdata[7:0];
        end
        if (be[1])
        begin
            res[15:8] = wdata[15:8];
        end
        return res;
    endfunction : gpcb_merge

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        cur_next = cur_reg;
        // answer handshake: wait one cycle, then release
        cur_next.ack = req & ~cur_reg.ack;
        if (req && !cur_reg.ack)
        begin
            cur_next.rdata = rd_val;
        end
        // register writes; unmapped writes are dropped
        if (wr_acc && hit_func)
        begin
            cur_next.func = gpcb_merge(cur_reg.func, i_avs_writedata,
                                       i_avs_byteenable);
        end
        if (wr_acc && hit_dir)
        begin
            cur_next.dir = gpcb_merge(cur_reg.dir, i_avs_writedata,
                                      i_avs_byteenable);
        end
        if (wr_acc && hit_data)
        begin
            // latch always loads; only output pins show it
            cur_next.dout = gpcb_merge(cur_reg.dout, i_avs_writedata,
                                       i_avs_byteenable);
        end
        // pad mux: alternate owns its pins, direction unused there
        cur_next.pad.out  = (cur_reg.func & i_alt.out)
                          | (~cur_reg.func & cur_reg.dout);
        cur_next.pad.oe_n = (cur_reg.func & i_alt.oe_n)
                          | (~cur_reg.func & ~cur_reg.dir);
        // lesser reset only clears the bus side; fields are sticky
        if (i_soft_reset)
        begin
            cur_next.ack   = 1'b0;
            cur_next.rdata = GPCB_RD_NONE;
        end
        if (i_reset)
        begin
            cur_next.func     = GPCB_FUNC_RST;
            cur_next.dir      = GPCB_DIR_RST;
            cur_next.dout     = GPCB_DOUT_RST;
            cur_next.ack      = 1'b0;
            cur_next.rdata    = GPCB_RD_NONE;
            cur_next.pad.out  = GPCB_DOUT_RST;
            cur_next.pad.oe_n = GPCB_OEN_RST;
        end
    end

    // register the whole state
    always_ff @(posedge i_clk)
    begin
        cur_reg <= cur_next;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_avs_waitrequest = req & ~cur_reg.ack;
    assign o_avs_readdata    = cur_reg.rdata;
    assign o_pad             = cur_reg.pad;
    assign o_pin_level       = level;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    property p_alt_level;
        ##1 (((o_pad.out ^ $past(i_alt.out)) & $past(cur_reg.func))
            == 16'h0000);
    endproperty
    a_alt_level: assert property (p_alt_level)
        else $error("alternate pin level not passed through");

    property p_gp_enable;
        ##1 ((~$past(cur_reg.func) & (o_pad.oe_n ^ ~$past(cur_reg.dir)))
            == 16'h0000);
    endproperty
    a_gp_enable: assert property (p_gp_enable)
        else $error("general pin enable not from direction");

    property p_gp_drive;
        ##1 (((o_pad.out ^ $past(cur_reg.dout)) & ~$past(cur_reg.func)
             & $past(cur_reg.dir)) == 16'h0000);
    endproperty
    a_gp_drive: assert property (p_gp_drive)
        else $error("general output not driving latch value");

    property p_gp_input;
        ##1 ((~$past(cur_reg.func) & ~$past(cur_reg.dir) & ~o_pad.oe_n)
            == 16'h0000);
    endproperty
    a_gp_input: assert property (p_gp_input)
        else $error("general input pin is driven");

    property p_alt_enable;
        ##1 (((o_pad.oe_n ^ $past(i_alt.oe_n)) & $past(cur_reg.func))
            == 16'h0000);
    endproperty
    a_alt_enable: assert property (p_alt_enable)
        else $error("alternate pin enable not passed through");

    property p_data_read;
        (i_avs_read && !o_avs_waitrequest && hit_data
         && !$past(i_soft_reset))
        |-> (o_avs_readdata == {GPCB_HI_ZERO, $past(level)});
    endproperty
    a_data_read: assert property (p_data_read)
        else $error("data read not the live pin level");

    property p_data_write;
        (wr_acc && hit_data && i_avs_byteenable[1:0] == 2'b11)
        |=> (cur_reg.dout == $past(i_avs_writedata[15:0]));
    endproperty
    a_data_write: assert property (p_data_write)
        else $error("data write not latched");

    property p_sticky;
        (i_soft_reset && !wr_acc)
        |=> (cur_reg.func == $past(cur_reg.func))
            && (cur_reg.dir == $past(cur_reg.dir));
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("fields lost on lesser reset");

    property p_reset_clear;
        $past(i_reset) |-> (cur_reg.func == GPCB_FUNC_RST)
                           && (o_pad.oe_n == GPCB_OEN_RST);
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("fundamental reset left pins configured");

    c_func_write: cover property (wr_acc && hit_func);
    c_data_read:  cover property (i_avs_read && cur_reg.ack && hit_data);
    c_gp_output:  cover property ((~cur_reg.func & cur_reg.dir) != 0);
    c_alt_pin:    cover property (cur_reg.func != 0);

endmodule : gpcb_top

// ### bench/gpio_pin_control_bank_test.sv
`timescale 1ns/1ps
module gpio_pin_control_bank_test;
    import gpcb_pkg::*;
    // ------------------------------------------------------------
    // bench signals
    // ------------------------------------------------------------
    logic        i_clk        = 1'b0;     // 40 MHz clock
    logic        i_reset      = 1'b1;     // fundamental reset
    logic        i_soft_reset = 1'b0;     // lesser reset
    logic [11:0] bus_addr     = 12'h000;  // byte address
    logic        bus_rd       = 1'b0;     // read request
    logic        bus_wr       = 1'b0;     // write request
    logic [31:0] bus_wdata    = 32'h0;    // write data
    logic [31:0] bus_rdata;               // read data from block
    logic        bus_wait;                // waitrequest
    logic [15:0] pins         = 16'h0;    // pad receiver levels
    gpcb_pad_t   alt          = '0;       // alternate drive request
    gpcb_pad_t   pad;                     // pad drivers
    logic [15:0] pin_lvl;                 // synchronised pin levels
    logic [31:0] rd;                      // last word read
    logic [15:0] func_v, dir_v, dout_v;   // values written
    integer      seed = 32'hBC19CFB4;     // fixed seed
    integer      cyc = 0, n_mismatch = 0, cmp_count = 0, i;

    always #12.5 i_clk = ~i_clk;

    gpcb_top i_dut (
        .i_clk             (i_clk),
        .i_reset           (i_reset),
        .i_soft_reset      (i_soft_reset),
        .i_avs_address     (bus_addr),
        .i_avs_read        (bus_rd),
        .i_avs_write       (bus_wr),
        .i_avs_writedata   (bus_wdata),
        .i_avs_byteenable  (4'hF),
        .o_avs_readdata    (bus_rdata),
        .o_avs_waitrequest (bus_wait),
        .i_pin_level       (pins),
        .i_alt             (alt),
        .o_pad             (pad),
        .o_pin_level       (pin_lvl)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // verdict in one place, also reached from the watchdog
    task automatic test_done;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count,
                     n_mismatch);
            if (n_mismatch == 0 && cmp_count > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask : test_done

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        begin
            cmp_count++;
            if (got !== exp)
            begin
                n_mismatch++;
                $display("Error %s expected %h seen %h", what, exp, got);
            end
        end
    endtask : check

    // one bus cycle; held until waitrequest is seen low at an edge;
    // only the watchdog ends a wait that never finishes
    task automatic bus(input logic wr, input logic [11:0] a,
                       input logic [15:0] d, output logic [31:0] q);
        integer n;
        begin
            n = 0;
            @(posedge i_clk);
            bus_wr    <= wr;
            bus_rd    <= !wr;
            bus_addr  <= a;
            bus_wdata <= {16'h0, d};
            do
            begin
                @(posedge i_clk);
                n++;
            end
            while (bus_wait !== 1'b0);
            // one wait state per request: answer at the second edge
            check("bus wait cycles", 32'h2, n);
            q = bus_rdata;
            bus_wr <= 1'b0;
            bus_rd <= 1'b0;
        end
    endtask : bus

    // pad expectation; level only compared where it is defined
    task automatic check_pad;
        logic [15:0] m, eo, ee;
        begin
            m  = func_v | dir_v;
            ee = (func_v & alt.oe_n) | (~func_v & ~dir_v);
            eo = ((func_v & alt.out) | (~func_v & dir_v & dout_v)) & m;
            check("pad enable", {16'h0, ee},
                  {16'h0, pad.oe_n});
            check("pad level", {16'h0, eo},
                  {16'h0, pad.out & m});
        end
    endtask : check_pad

    // watchdog: the whole run needs well under this many cycles
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (16) @(posedge i_clk);
        i_reset <= 1'b0;
        bus(1'b0, GPCB_FUNC_OFS, 16'h0, rd);
        check("func after reset", 32'h0, rd);
        bus(1'b0, GPCB_DIR_OFS, 16'h0, rd);
        check("dir after reset", 32'h0, rd);
        bus(1'b0, 12'h424, 16'h0, rd);
        check("unmapped read", GPCB_RD_NONE, rd);
        $display("test reset done");
        // corners first: all outputs, all alternate, all inputs
        for (i = 0; i < 24; i++)
        begin
            {dir_v, func_v} = $random(seed);
            // pins change by non-blocking assignment, off the sampling
            {pins, dout_v} <= $random(seed);
            if (i == 0) {func_v, dir_v} = {16'h0000, 16'hFFFF};
            if (i == 1) {func_v, dir_v} = {16'hFFFF, 16'hFFFF};
            if (i == 2) {func_v, dir_v} = {16'h0000, 16'h0000};
            alt <= $random(seed);
            bus(1'b1, GPCB_FUNC_OFS, func_v, rd);
            bus(1'b1, GPCB_DIR_OFS, dir_v, rd);
            bus(1'b1, GPCB_DATA_OFS, dout_v, rd);
            repeat (2) @(posedge i_clk);
            check_pad();
            // pins settled long ago, sync delay is well covered
            bus(1'b0, GPCB_DATA_OFS, 16'h0, rd);
            check("data read", {16'h0, pins}, rd);
            check("pin level", {16'h0, pins}, {16'h0, pin_lvl});
        end
        $display("test pad mux done");
        // lesser reset must leave configuration alone
        i_soft_reset <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_soft_reset <= 1'b0;
        bus(1'b0, GPCB_FUNC_OFS, 16'h0, rd);
        check("func sticky", {16'h0, func_v}, rd);
        bus(1'b0, GPCB_DIR_OFS, 16'h0, rd);
        check("dir sticky", {16'h0, dir_v}, rd);
        // fundamental reset mid-run clears it and frees every pin
        i_reset <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        check("pads after reset", {16'h0, GPCB_OEN_RST},
              {16'h0, pad.oe_n});
        bus(1'b0, GPCB_DIR_OFS, 16'h0, rd);
        check("dir after second reset", 32'h0, rd);
        $display("test sticky done");
        test_done();
    end
endmodule : gpio_pin_control_bank_test
